// ### verilog/afr_pkg.sv
// Constants, types and register map of the converter filter path block.
// Assumes a single system clock and an APB master with 32-bit data.
// Functional notes
// - Averaging enable set routes averaged converter output to the transform engine.
// - Control bit 6 bypasses the third-order decimation filter when set.
// - With that filter bypassed, raw samples at either rate enter gain/offset correction.
// - Bypassed, slow rate and averaging off: gain/offset output becomes the transform input.
// - Bypass gives the transform engine unattenuated samples at the top frequency.
// - Notch bypass bit 4 clear runs mains rejection and fills the notch result.
// - Notch bypass bit set skips both mains rejection filters.
// - Control bit 0 picks raw rate: one is slower, zero is faster.
// - Converter result shows an unsigned 16-bit value in its low bits.
// - Converter result holds raw, third-order or notch filter output per configuration.
// - Real transform result shows an 18-bit two's complement value, low bits.
// - Imaginary transform result shows an 18-bit two's complement value, low bits.
// - Converter result sits at 0x2074 and resets to zero.
// - Real and imaginary results sit at 0x2078 and 0x207C, reset zero.
// - Averaging enable is control bit 7 and switches the transform source.
// - Averaging enable overrides the transform input select field.
// - Each new notch result sets interrupt flag bit 2.
package afr_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [31:0] CTRL_OFS     = 32'h0000_2044;
  localparam logic [31:0] CONV_OFS     = 32'h0000_2074;
  localparam logic [31:0] REAL_OFS     = 32'h0000_2078;
  localparam logic [31:0] IMAG_OFS     = 32'h0000_207C;
  localparam logic [31:0] NOTCH_OFS    = 32'h0000_2080;
  localparam logic [31:0] CORR_OFS     = 32'h0000_2088;
  localparam logic [31:0] XSEL_OFS     = 32'h0000_208C;
  localparam logic [31:0] IRQ_STAT_OFS = 32'h0000_3000;
  localparam logic [31:0] IRQ_MASK_OFS = 32'h0000_3004;

  // ****************************************************************
  // Field positions and reset values
  // ****************************************************************
  localparam int RATE_BIT      = 0;
  localparam int NOTCH_BYP_BIT = 4;
  localparam int S3_BYP_BIT    = 6;
  localparam int AVG_EN_BIT    = 7;
  localparam logic [7:0]  CTRL_RST  = 8'h00;
  localparam logic [15:0] CORR_RST  = 16'h0000;
  localparam logic [1:0]  XSEL_RST  = 2'h0;
  localparam int IRQ_W         = 3;
  localparam int IRQ_CONV_BIT  = 0;
  localparam int IRQ_XFORM_BIT = 1;
  localparam int IRQ_NOTCH_BIT = 2;
  localparam logic [IRQ_W-1:0] IRQ_RST = 3'h0;

  // ****************************************************************
  // Decimation ratios of the third-order stage per raw rate
  // ****************************************************************
  localparam logic [7:0] S3_OSR_SLOW = 8'h05;
  localparam logic [7:0] S3_OSR_FAST = 8'h04;

  typedef enum logic [1:0] {
    AFR_XSEL_NOTCH   = 2'b00,
    AFR_XSEL_CORR    = 2'b01,
    AFR_XSEL_RAW     = 2'b10,
    AFR_XSEL_NOTCH_B = 2'b11
  } afr_xsel_t;

  typedef struct packed {
    logic        valid;
    logic [15:0] data;
  } afr_smp_t;

  typedef struct packed {
    logic        avg_en;
    logic        s3_byp;
    logic        notch_byp;
    logic        rate_slow;
  } afr_ctrl_t;

endpackage : afr_pkg

// ### verilog/afr_decim.sv
// Boxcar decimator: averages ratio_i input samples into one output sample.
// Assumes ratio_i is at least one and held steady while samples flow.
`timescale 1ns/100ps
`default_nettype none
module afr_decim
  import afr_pkg::*;
#(
  parameter int RW = 8
) (
  input  wire logic          ref_clk_i,
  input  wire logic          rst_b_i,
  input  wire logic          clr_i,
  input  wire logic [RW-1:0] ratio_i,
  input  wire afr_smp_t      smp_i,
  output afr_smp_t           smp_o
);

  logic [15+RW:0] acc_reg;
  logic [RW-1:0]  cnt_reg;
  logic [15+RW:0] sum;
  logic [15+RW:0] quot;

  assign sum  = acc_reg + {{RW{1'b0}}, smp_i.data};
  // Division by a small runtime ratio keeps one structure for every rate.
  assign quot = sum / {{16{1'b0}}, ratio_i};

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      acc_reg <= '0;
      cnt_reg <= '0;
      smp_o   <= '0;
    end else if (clr_i) begin
      acc_reg <= '0;
      cnt_reg <= '0;
      smp_o   <= '0;
    end else begin
      smp_o.valid <= 1'b0;
      if (smp_i.valid) begin
        if (cnt_reg + 1'b1 >= ratio_i) begin
          acc_reg    <= '0;
          cnt_reg    <= '0;
          smp_o.valid <= 1'b1;
          smp_o.data <= quot[15:0];
        end else begin
          acc_reg <= sum;
          cnt_reg <= cnt_reg + 1'b1;
        end
      end
    end
  end

endmodule : afr_decim
`default_nettype wire

// ### verilog/afr_filter_path.sv
// Top of the converter filter path: control, data path muxing, results, APB.
// Assumes raw samples and transform results are synchronous to ref_clk_i.
//
// The APB interface to the registers was decided locally.
`timescale 1ns/100ps
`default_nettype none
module afr_filter_path
  import afr_pkg::*;
#(
  parameter logic [7:0] NOTCH_OSR = 8'd22,
  parameter logic [7:0] AVG_COUNT = 8'd16
) (
  input  wire logic        ref_clk_i,
  input  wire logic        rst_b_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [31:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic [31:0]      prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  input  wire afr_smp_t    raw_smp_i,
  input  wire logic [17:0] xform_real_i,
  input  wire logic [17:0] xform_imag_i,
  input  wire logic        xform_done_i,
  output afr_smp_t         xform_smp_o,
  output logic             raw_rate_select_o,
  output logic             irq_o
);

  // ****************************************************************
  // Register storage
  // ****************************************************************
  afr_ctrl_t        ctrl_reg;
  logic [15:0]      corr_offset_reg;
  afr_xsel_t        xsel_reg;
  logic [15:0]      conv_reg;
  logic [17:0]      real_reg;
  logic [17:0]      imag_reg;
  logic [15:0]      notch_reg;
  logic [IRQ_W-1:0] irq_stat_reg;
  logic [IRQ_W-1:0] irq_mask_reg;
  logic [IRQ_W-1:0] irq_snap_reg;
  logic [IRQ_W-1:0] irq_set;
  logic [IRQ_W-1:0] irq_clr;

  // ****************************************************************
  // APB decode
  // ****************************************************************
  logic        setup;
  logic        done;
  logic        wr_done;
  logic [31:0] rd_val;
  logic        rd_hit;

  assign setup   = psel_i && !penable_i && !pready_o;
  assign done    = psel_i && penable_i && pready_o;
  assign wr_done = done && pwrite_i;

  // ****************************************************************
  // Write and clear strobes
  // ****************************************************************
  logic wr_ctrl;
  logic wr_corr;
  logic wr_xsel;
  logic wr_mask;
  logic rd_stat;

  // Only writable words get a strobe; result and status words ignore writes.
  always_comb begin
    wr_ctrl = 1'b0;
    wr_corr = 1'b0;
    wr_xsel = 1'b0;
    wr_mask = 1'b0;
    if (wr_done) begin
      if (paddr_i == CTRL_OFS) begin
        wr_ctrl = 1'b1;
      end else if (paddr_i == CORR_OFS) begin
        wr_corr = 1'b1;
      end else if (paddr_i == XSEL_OFS) begin
        wr_xsel = 1'b1;
      end else if (paddr_i == IRQ_MASK_OFS) begin
        wr_mask = 1'b1;
      end
    end
  end

  // A status read clears at the access edge, the same edge that takes the data.
  assign rd_stat = done && !pwrite_i && paddr_i == IRQ_STAT_OFS;

  // Reserved bits are padded with zero here.
  always_comb begin
    rd_val = 32'h0000_0000;
    rd_hit = 1'b1;
    if (paddr_i == CTRL_OFS) begin
      rd_val[AVG_EN_BIT]    = ctrl_reg.avg_en;
      rd_val[S3_BYP_BIT]    = ctrl_reg.s3_byp;
      rd_val[NOTCH_BYP_BIT] = ctrl_reg.notch_byp;
      rd_val[RATE_BIT]      = ctrl_reg.rate_slow;
    end else if (paddr_i == CONV_OFS) begin
      rd_val[15:0] = conv_reg;
    end else if (paddr_i == REAL_OFS) begin
      rd_val[17:0] = real_reg;
    end else if (paddr_i == IMAG_OFS) begin
      rd_val[17:0] = imag_reg;
    end else if (paddr_i == NOTCH_OFS) begin
      rd_val[15:0] = notch_reg;
    end else if (paddr_i == CORR_OFS) begin
      rd_val[15:0] = corr_offset_reg;
    end else if (paddr_i == XSEL_OFS) begin
      rd_val[1:0] = xsel_reg;
    end else if (paddr_i == IRQ_STAT_OFS) begin
      rd_val[IRQ_W-1:0] = irq_stat_reg;
    end else if (paddr_i == IRQ_MASK_OFS) begin
      rd_val[IRQ_W-1:0] = irq_mask_reg;
    end else begin
      rd_hit = 1'b0;
    end
  end

  // The answer is prepared in the setup cycle, so every access has no wait.
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pready_o  <= 1'b0;
      prdata_o  <= 32'h0000_0000;
      pslverr_o <= 1'b0;
    end else begin
      pready_o  <= setup;
      prdata_o  <= (setup && !pwrite_i) ? rd_val : 32'h0000_0000;
      pslverr_o <= setup && !rd_hit;
    end
  end

  // ****************************************************************
  // Software controlled registers
  // ****************************************************************
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ctrl_reg <= afr_ctrl_t'({CTRL_RST[AVG_EN_BIT], CTRL_RST[S3_BYP_BIT],
                               CTRL_RST[NOTCH_BYP_BIT], CTRL_RST[RATE_BIT]});
    end else if (wr_ctrl) begin
      // Only the defined bits are stored; the rest of the word is dropped.
      ctrl_reg.avg_en    <= pwdata_i[AVG_EN_BIT];
      ctrl_reg.s3_byp    <= pwdata_i[S3_BYP_BIT];
      ctrl_reg.notch_byp <= pwdata_i[NOTCH_BYP_BIT];
      ctrl_reg.rate_slow <= pwdata_i[RATE_BIT];
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      corr_offset_reg <= CORR_RST;
      xsel_reg        <= afr_xsel_t'(XSEL_RST);
    end else if (wr_corr) begin
      corr_offset_reg <= pwdata_i[15:0];
    end else if (wr_xsel) begin
      xsel_reg <= afr_xsel_t'(pwdata_i[1:0]);
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      irq_mask_reg <= IRQ_RST;
    end else if (wr_mask) begin
      irq_mask_reg <= pwdata_i[IRQ_W-1:0];
    end
  end

  // The raw rate goes to the converter; the analog clock must already suit it.
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      raw_rate_select_o <= CTRL_RST[RATE_BIT];
    end else begin
      raw_rate_select_o <= ctrl_reg.rate_slow;
    end
  end

  // ****************************************************************
  // Decimation and correction path
  // ****************************************************************
  afr_smp_t   s3_smp;
  afr_smp_t   pre_corr;
  afr_smp_t   corr_reg;
  afr_smp_t   notch_smp;
  afr_smp_t   avg_smp;
  logic [7:0] s3_ratio;

  assign s3_ratio = ctrl_reg.rate_slow ? S3_OSR_SLOW : S3_OSR_FAST;

  afr_decim #(
    .RW (8)
  ) u_s3 (
    .ref_clk_i (ref_clk_i),
    .rst_b_i   (rst_b_i),
    .clr_i     (ctrl_reg.s3_byp),
    .ratio_i   (s3_ratio),
    .smp_i     (raw_smp_i),
    .smp_o     (s3_smp)
  );

  // Bypass hands raw samples at either rate straight to correction.
  assign pre_corr = ctrl_reg.s3_byp ? raw_smp_i : s3_smp;

  // Offset correction saturates at zero so the result stays unsigned.
  function automatic logic [15:0] sub_floor(input logic [15:0] value,
                                            input logic [15:0] offset);
    logic [15:0] res;
    res = 16'h0000;
    if (value > offset) begin
      res = value - offset;
    end
    return res;
  endfunction : sub_floor

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      corr_reg <= '0;
    end else begin
      corr_reg.valid <= pre_corr.valid;
      if (pre_corr.valid) begin
        corr_reg.data <= sub_floor(pre_corr.data, corr_offset_reg);
      end
    end
  end

  // Holding the notch stage clear while bypassed skips both rejections.
  afr_decim #(
    .RW (8)
  ) u_notch (
    .ref_clk_i (ref_clk_i),
    .rst_b_i   (rst_b_i),
    .clr_i     (ctrl_reg.notch_byp),
    .ratio_i   (NOTCH_OSR),
    .smp_i     (corr_reg),
    .smp_o     (notch_smp)
  );

  afr_decim #(
    .RW (8)
  ) u_avg (
    .ref_clk_i (ref_clk_i),
    .rst_b_i   (rst_b_i),
    .clr_i     (!ctrl_reg.avg_en),
    .ratio_i   (AVG_COUNT),
    .smp_i     (corr_reg),
    .smp_o     (avg_smp)
  );

  // ****************************************************************
  // Result registers
  // ****************************************************************
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      notch_reg <= 16'h0000;
    end else if (notch_smp.valid) begin
      notch_reg <= notch_smp.data;
    end
  end

  afr_smp_t conv_src;

  // Notch output when it runs, else the corrected raw or third-order data.
  assign conv_src = ctrl_reg.notch_byp ? corr_reg : notch_smp;

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      conv_reg <= 16'h0000;
    end else if (conv_src.valid) begin
      conv_reg <= conv_src.data;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      real_reg <= 18'h0_0000;
      imag_reg <= 18'h0_0000;
    end else if (xform_done_i) begin
      real_reg <= xform_real_i;
      imag_reg <= xform_imag_i;
    end
  end

  // ****************************************************************
  // Transform input selection
  // ****************************************************************
  afr_smp_t xform_src;

  always_comb begin
    if (ctrl_reg.avg_en) begin
      xform_src = avg_smp;
    end else if (ctrl_reg.s3_byp && ctrl_reg.rate_slow) begin
      // No third-order droop reaches the engine in this path.
      xform_src = corr_reg;
    end else begin
      case (xsel_reg)
        AFR_XSEL_CORR: xform_src = corr_reg;
        // Raw data is only usable at the slow rate; fall back to correction.
        AFR_XSEL_RAW:  xform_src = ctrl_reg.rate_slow ? raw_smp_i : corr_reg;
        default:       xform_src = ctrl_reg.notch_byp ? corr_reg : notch_smp;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      xform_smp_o <= '0;
    end else begin
      xform_smp_o <= xform_src;
    end
  end

  // ****************************************************************
  // Interrupt flags
  // ****************************************************************
  always_comb begin
    irq_set                = '0;
    irq_set[IRQ_CONV_BIT]  = conv_src.valid;
    irq_set[IRQ_XFORM_BIT] = xform_done_i;
    irq_set[IRQ_NOTCH_BIT] = notch_smp.valid;
  end

  // Only bits that the read actually returned are cleared, so a flag raised
  // between the setup and access cycles survives for the next read.
  assign irq_clr = rd_stat ? irq_snap_reg : '0;

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      irq_snap_reg <= IRQ_RST;
    end else if (setup) begin
      irq_snap_reg <= irq_stat_reg;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      irq_stat_reg <= IRQ_RST;
    end else begin
      irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_set;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(((irq_stat_reg & ~irq_clr) | irq_set) & irq_mask_reg);
    end
  end

endmodule : afr_filter_path
`default_nettype wire

// ### tb/afr_filter_path_monitor.sv
// Concurrent checks on the ports of the converter filter path top.
// Assumes it is bound to afr_filter_path and sees only that module's ports.
`timescale 1ns/100ps
`default_nettype none
module afr_filter_path_monitor
  import afr_pkg::*;
#(
  parameter logic [7:0] NOTCH_OSR = 8'd22,
  parameter logic [7:0] AVG_COUNT = 8'd16
) (
  input wire logic        ref_clk_i,
  input wire logic        rst_b_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [31:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic        pready_o,
  input wire logic        pslverr_o,
  input wire afr_smp_t    raw_smp_i,
  input wire logic [17:0] xform_real_i,
  input wire logic [17:0] xform_imag_i,
  input wire logic        xform_done_i,
  input wire afr_smp_t    xform_smp_o,
  input wire logic        raw_rate_select_o,
  input wire logic        irq_o
);
  default clocking mon_cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_b_i);

  logic setup;
  logic rd_acc;
  logic mapped;
  assign setup  = psel_i && !penable_i;
  assign rd_acc = psel_i && penable_i && !pwrite_i && pready_o;
  assign mapped = paddr_i inside {CTRL_OFS, CONV_OFS, REAL_OFS, IMAG_OFS, NOTCH_OFS,
                                  CORR_OFS, XSEL_OFS, IRQ_STAT_OFS, IRQ_MASK_OFS};

  ready_after_setup_a: assert property (setup |=> pready_o)
    else $error("no answer after setup");
  ready_single_a: assert property (pready_o |=> !pready_o)
    else $error("ready longer than one cycle");
  ready_cause_a: assert property (pready_o |-> $past(setup))
    else $error("ready without setup");
  error_unmapped_a: assert property (setup && !mapped |=> pslverr_o)
    else $error("unmapped access not refused");
  error_mapped_a: assert property (setup && mapped |=> !pslverr_o)
    else $error("mapped access refused");
  idle_zero_a: assert property (!pready_o |-> prdata_o == 32'h0000_0000)
    else $error("read data outside access");
  conv_pad_a: assert property (rd_acc && paddr_i == CONV_OFS |-> prdata_o[31:16] == 16'h0000)
    else $error("converter result upper bits set");
  xform_pad_a: assert property (rd_acc && (paddr_i == REAL_OFS || paddr_i == IMAG_OFS)
                                |-> prdata_o[31:18] == 14'h0000)
    else $error("transform result upper bits set");
  ctrl_pad_a: assert property (rd_acc && paddr_i == CTRL_OFS
                               |-> (prdata_o & 32'hFFFF_FF2E) == 32'h0000_0000)
    else $error("control reserved bits set");
  rate_copy_a: assert property (psel_i && penable_i && pwrite_i && pready_o && paddr_i == CTRL_OFS
                                |-> ##2 raw_rate_select_o == $past(pwdata_i[RATE_BIT], 2))
    else $error("rate select does not follow control");
endmodule : afr_filter_path_monitor
`default_nettype wire

// ### tb/afr_filter_path_tb_top.sv
// Self-checking bench for the converter filter path block.
// Assumes afr_pkg, the design and the monitor are compiled before this file.
`timescale 1ns/100ps
`default_nettype none
module afr_filter_path_tb_top
  import afr_pkg::*;
;
  logic        clk;
  logic        rst_b;
  logic        psel, penable, pwrite, done, xchk, pready, pslverr, rate_sel, irq;
  logic [31:0] paddr, pwdata, prdata;
  logic [17:0] re, im;
  logic [15:0] v, u;
  afr_smp_t    raw, xs;
  logic [32:0] rq[$];
  logic [15:0] xq[$];
  int          err_count, n_tests;

  // Small averaging counts keep the run short.
  afr_filter_path #(.NOTCH_OSR(8'd2), .AVG_COUNT(8'd2)) dut (
    .ref_clk_i(clk), .rst_b_i(rst_b), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .raw_smp_i(raw), .xform_real_i(re),
    .xform_imag_i(im), .xform_done_i(done), .xform_smp_o(xs),
    .raw_rate_select_o(rate_sel), .irq_o(irq));

  initial clk = 1'b0;
  always #20 clk = ~clk;

  task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : wrap_up

  // One extra edge after release keeps two transfers from driving psel in one step.
  task automatic apb(input logic w, input logic [31:0] a, d, input logic [32:0] e);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    if (!w) rq.push_back(e);
    @(posedge clk);
    penable <= 1'b1;
    // The request stands until the rising edge at which pready is seen high.
    for (n = 0; n < 20; n++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    if (n == 20) begin
      err_count++;
      wrap_up();
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb

  task automatic wr(input logic [31:0] a, d);
    apb(1'b1, a, d, 33'h0);
  endtask : wr

  task automatic rd(input logic [31:0] a, input logic [32:0] e);
    apb(1'b0, a, 32'h0, e);
  endtask : rd

  task automatic burst(input int n, input logic [15:0] val, input bit rnd, input bit ex);
    for (int i = 0; i < n; i++) begin
      v = rnd ? 16'($urandom) : val;
      raw <= '{1'b1, v};
      if (ex) xq.push_back(v);
      @(posedge clk);
    end
    raw.valid <= 1'b0;
    repeat (4) @(posedge clk);
  endtask : burst

  // ****************************************************************
  // Output watcher
  // ****************************************************************
  always @(posedge clk) begin
    if (pready === 1'b1 && penable && !pwrite) begin
      if (rq.size() > 0) chk({pslverr, prdata}, rq.pop_front());
      else chk(33'h0, 33'h1);
    end
    if (xs.valid === 1'b1 && xchk) begin
      if (xq.size() > 0) chk(33'(xs.data), 33'(xq.pop_front()));
      else chk(33'h0, 33'h1);
    end
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    void'($urandom(85527));
    {psel, penable, pwrite, done, xchk} = '0;
    {paddr, pwdata, re, im, raw} = '0;
    err_count = 0;
    n_tests = 0;
    rst_b = 1'b0;
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    rd(CONV_OFS, 33'h0);
    rd(REAL_OFS, 33'h0);
    rd(IMAG_OFS, 33'h0);
    rd(32'h0000_2070, 33'h1_0000_0000);
    wr(CTRL_OFS, 32'hFFFF_FFFF);
    rd(CTRL_OFS, 33'h0_0000_00D1);
    chk(rate_sel, 1'b1);
    wr(CTRL_OFS, 32'h0000_0000);
    @(posedge clk);
    chk(rate_sel, 1'b0);
    wr(IRQ_MASK_OFS, 32'hFFFF_FFFF);
    rd(IRQ_MASK_OFS, 33'h7);
    wr(CTRL_OFS, 32'h0000_0051);
    xchk <= 1'b1;
    burst(4, 16'h0000, 1'b1, 1'b1);
    chk(irq, 1'b1);
    wr(CONV_OFS, 32'hFFFF_FFFF);
    rd(CONV_OFS, {17'h0, v});
    rd(IRQ_STAT_OFS, 33'h1);
    rd(IRQ_STAT_OFS, 33'h0);
    chk(irq, 1'b0);
    wr(CTRL_OFS, 32'h0000_00D1);
    wr(XSEL_OFS, 32'h0000_0002);
    u = 16'($urandom);
    xq.push_back(u);
    xq.push_back(u);
    burst(4, u, 1'b0, 1'b0);
    rd(IRQ_STAT_OFS, 33'h1);
    wr(XSEL_OFS, 32'h0000_0000);
    xchk <= 1'b0;
    wr(CTRL_OFS, 32'h0000_0041);
    u = 16'($urandom);
    burst(1, u, 1'b0, 1'b0);
    rd(IRQ_STAT_OFS, 33'h0);
    burst(1, u, 1'b0, 1'b0);
    rd(IRQ_STAT_OFS, 33'h5);
    rd(NOTCH_OFS, {17'h0, u});
    rd(CONV_OFS, {17'h0, u});
    wr(CTRL_OFS, 32'h0000_0051);
    burst(2, 16'h0000, 1'b1, 1'b0);
    rd(NOTCH_OFS, {17'h0, u});
    rd(IRQ_STAT_OFS, 33'h1);
    wr(CTRL_OFS, 32'h0000_0011);
    burst(10, ~u, 1'b0, 1'b0);
    burst(1, u, 1'b0, 1'b0);
    rd(CONV_OFS, {17'h0, ~u});
    rd(IRQ_STAT_OFS, 33'h1);
    wr(CTRL_OFS, 32'h0000_0051);
    wr(CORR_OFS, {16'h0000, u});
    rd(CORR_OFS, {17'h0, u});
    burst(1, ~u, 1'b0, 1'b0);
    v = (~u > u) ? ~u - u : 16'h0000;
    rd(CONV_OFS, {17'h0, v});
    rd(IRQ_STAT_OFS, 33'h1);
    wr(CTRL_OFS, 32'h0000_0011);
    wr(XSEL_OFS, 32'h0000_0002);
    xchk <= 1'b1;
    burst(2, 16'h0000, 1'b1, 1'b1);
    xchk <= 1'b0;
    re <= 18'($urandom);
    im <= 18'($urandom);
    done <= 1'b1;
    @(posedge clk);
    done <= 1'b0;
    rd(REAL_OFS, {15'h0, re});
    rd(IMAG_OFS, {15'h0, im});
    wr(IRQ_MASK_OFS, 32'h0000_0001);
    @(posedge clk);
    chk(irq, 1'b0);
    wr(IRQ_MASK_OFS, 32'h0000_0002);
    @(posedge clk);
    chk(irq, 1'b1);
    rd(IRQ_STAT_OFS, 33'h2);
    @(posedge clk);
    chk(irq, 1'b0);
    chk(33'(rq.size()), 33'h0);
    chk(33'(xq.size()), 33'h0);
    wrap_up();
  end
endmodule : afr_filter_path_tb_top

bind afr_filter_path afr_filter_path_monitor #(
  .NOTCH_OSR(NOTCH_OSR), .AVG_COUNT(AVG_COUNT)
) mon (
  .ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .psel_i(psel_i), .penable_i(penable_i),
  .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
  .pready_o(pready_o), .pslverr_o(pslverr_o), .raw_smp_i(raw_smp_i),
  .xform_real_i(xform_real_i), .xform_imag_i(xform_imag_i), .xform_done_i(xform_done_i),
  .xform_smp_o(xform_smp_o), .raw_rate_select_o(raw_rate_select_o), .irq_o(irq_o));
`default_nettype wire
